// *** rtl/pwd_flags.sv ***
`timescale 1ns/1ns
module pwd_flags #(
   parameter int N = 4
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [N-1:0] set,
   input wire logic clear,
   output logic [N-1:0] flags
);
   logic [N-1:0] next_flags;

   // a set in the clearing cycle survives
   always_comb begin
      next_flags = flags;
      if (clear) begin
         next_flags = '0;
      end
      next_flags = next_flags | set;
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         flags <= '0;
      end else begin
         flags <= next_flags;
      end
   end
endmodule

// *** rtl/pwd_pkg.sv ***
package pwd_pkg;
   localparam int NUM_PORTS = 4;
   // register offsets
   localparam logic [7:0] ADDR_HW_CONTROL_FLAGS = 8'h1C;
   localparam logic [7:0] ADDR_WATCHDOG_COUNT = 8'h1E;
   localparam logic [7:0] ADDR_SWITCH_MODE_CONFIG = 8'h1F;
   // reset values
   localparam logic [7:0] RST_HW_CONTROL_FLAGS = 8'h00;
   localparam logic [7:0] RST_WATCHDOG_COUNT = 8'h00;
   localparam logic [7:0] RST_SWITCH_MODE_CONFIG = 8'h00;
   // switch_mode_config fields
   localparam int BIT_WATCHDOG_ENABLE = 7;
   localparam int BIT_TAKEOVER_IRQ_ENABLE = 6;
   localparam int BIT_EXPIRY_MODE_SELECT_LO = 0;
   // bit 5 reserved, reads zero; bit 4 reserved but stored
   localparam logic [7:0] SWITCH_MODE_WRITE_MASK = 8'hDF;
   // port operating mode codes
   localparam logic [1:0] MODE_SHUTDOWN = 2'h0;
   localparam logic [1:0] MODE_AUTO = 2'h3;
   // decrement period
   localparam int unsigned TICK_MS = 164;
   localparam int unsigned CLK_KHZ = 20000;
   localparam int unsigned TICK_CYCLES = TICK_MS * CLK_KHZ;

   typedef struct packed {
      logic [7:0] addr;
      logic wr;
      logic rd;
      logic [7:0] wdata;
   } pwd_reg_req_t;

   typedef struct packed {
      logic valid;
      logic [NUM_PORTS-1:0][1:0] mode;
   } pwd_mode_cmd_t;
endpackage

// *** rtl/pwd_tick_div.sv ***
`timescale 1ns/1ns
module pwd_tick_div #(
   parameter int TICK_CYCLES = 3280000
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic run,
   output logic tick
);
   localparam int CNT_W = $clog2(TICK_CYCLES + 1);
   localparam logic [CNT_W-1:0] LAST = CNT_W'(TICK_CYCLES - 1);

   logic [CNT_W-1:0] cnt;
   logic [CNT_W-1:0] next_cnt;
   logic next_tick;

   // restarts a full period whenever the watchdog is stopped
   always_comb begin
      next_cnt = cnt;
      next_tick = 1'b0;
      if (!run) begin
         next_cnt = '0;
      end else if (cnt == LAST) begin
         next_cnt = '0;
         next_tick = 1'b1;
      end else begin
         next_cnt = cnt + CNT_W'(1);
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         cnt <= '0;
         tick <= 1'b0;
      end else begin
         cnt <= next_cnt;
         tick <= next_tick;
      end
   end
endmodule

// *** rtl/pwd_watchdog.sv ***
`timescale 1ns/1ns
// Notes on behaviour
// - countdown and takeover only while enable bit 7
// - count decrements once every 164ms
// - at zero, hardware takes over all ports
// - select bit zero forces port to shutdown
// - select bit one forces port to auto
// - port select bits in config bits 3:0
// - count is read/write register at 1Eh
// - power-on requests ignored under hardware control
// - mode changes rejected under hardware control
// - takeover sets every port's flag
// - refused power-on sets that port's flag
// - flags in bits 3:0, cleared on read
// - irq enable bit 6 raises interrupt on flags
// - reset clears the three registers to zero
// - interrupt needs global interrupt enable too
module pwd_watchdog
   import pwd_pkg::*;
#(
   parameter int TICK_CYCLES = pwd_pkg::TICK_CYCLES
) (
   input wire logic sys_clk,
   input wire logic rst,
   input pwd_reg_req_t reg_req,
   output logic [7:0] reg_rdata,
   input wire logic global_irq_enable,
   input wire logic [NUM_PORTS-1:0] power_on_req,
   input wire logic mode_wr_req,
   output logic [NUM_PORTS-1:0] power_on_grant,
   output logic mode_wr_accept,
   output pwd_mode_cmd_t mode_cmd,
   output logic hw_control_active,
   output logic irq
);
   logic [7:0] watchdog_count;
   logic [7:0] switch_mode_config;
   logic [7:0] next_watchdog_count;
   logic [7:0] next_switch_mode_config;
   logic next_hw_control_active;
   logic [NUM_PORTS-1:0] hw_control_flag;
   logic [NUM_PORTS-1:0] flag_set;
   logic flag_clear;
   logic tick;
   logic watchdog_enable;
   logic expire;
   logic wr_count;
   logic wr_config;
   pwd_mode_cmd_t next_mode_cmd;
   logic [NUM_PORTS-1:0] next_power_on_grant;
   logic next_mode_wr_accept;
   logic next_irq;
   logic [7:0] next_reg_rdata;
   logic [NUM_PORTS-1:0] expiry_mode_select;

   // register decode shared by writes, read mux and clear-on-read
   function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] target);
      return addr == target;
   endfunction

   assign watchdog_enable = switch_mode_config[BIT_WATCHDOG_ENABLE];
   assign expiry_mode_select = switch_mode_config[BIT_EXPIRY_MODE_SELECT_LO +: NUM_PORTS];
   assign wr_count = reg_req.wr && addr_hit(reg_req.addr, ADDR_WATCHDOG_COUNT);
   assign wr_config = reg_req.wr && addr_hit(reg_req.addr, ADDR_SWITCH_MODE_CONFIG);

   pwd_tick_div #(
      .TICK_CYCLES(TICK_CYCLES)
   ) u_tick (
      .sys_clk(sys_clk),
      .rst(rst),
      .run(watchdog_enable),
      .tick(tick)
   );

   // count and takeover state
   always_comb begin
      next_watchdog_count = watchdog_count;
      next_switch_mode_config = switch_mode_config;
      next_hw_control_active = hw_control_active;
      expire = 1'b0;
      if (wr_config) begin
         next_switch_mode_config = reg_req.wdata & SWITCH_MODE_WRITE_MASK;
      end
      if (wr_count) begin
         next_watchdog_count = reg_req.wdata;
      // no decrement or expiry in the cycle that turns the watchdog off
      end else if (watchdog_enable && next_switch_mode_config[BIT_WATCHDOG_ENABLE] && tick
                   && watchdog_count != 8'h00) begin
         next_watchdog_count = watchdog_count - 8'h01;
         expire = (watchdog_count == 8'h01);
      end
      if (expire) begin
         next_hw_control_active = 1'b1;
      end
      if (!next_switch_mode_config[BIT_WATCHDOG_ENABLE]) begin
         next_hw_control_active = 1'b0;
      end else if (wr_count && reg_req.wdata != 8'h00) begin
         next_hw_control_active = 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         watchdog_count <= RST_WATCHDOG_COUNT;
         switch_mode_config <= RST_SWITCH_MODE_CONFIG;
         hw_control_active <= 1'b0;
      end else begin
         watchdog_count <= next_watchdog_count;
         switch_mode_config <= next_switch_mode_config;
         hw_control_active <= next_hw_control_active;
      end
   end

   // forced mode, request gating, flag events
   always_comb begin
      next_mode_cmd.valid = expire;
      for (int i = 0; i < NUM_PORTS; i++) begin
         next_mode_cmd.mode[i] = expiry_mode_select[i] ? MODE_AUTO : MODE_SHUTDOWN;
      end
      next_power_on_grant = power_on_req & ~{NUM_PORTS{hw_control_active}};
      next_mode_wr_accept = mode_wr_req && !hw_control_active;
      flag_set = power_on_req & {NUM_PORTS{hw_control_active}};
      if (expire) begin
         flag_set = {NUM_PORTS{1'b1}};
      end
      flag_clear = reg_req.rd && addr_hit(reg_req.addr, ADDR_HW_CONTROL_FLAGS);
   end

   pwd_flags #(
      .N(NUM_PORTS)
   ) u_flags (
      .sys_clk(sys_clk),
      .rst(rst),
      .set(flag_set),
      .clear(flag_clear),
      .flags(hw_control_flag)
   );

   // read data and interrupt
   always_comb begin
      next_reg_rdata = reg_rdata;
      if (reg_req.rd) begin
         if (addr_hit(reg_req.addr, ADDR_HW_CONTROL_FLAGS)) begin
            next_reg_rdata = {{(8 - NUM_PORTS){1'b0}}, hw_control_flag};
         end else if (addr_hit(reg_req.addr, ADDR_WATCHDOG_COUNT)) begin
            next_reg_rdata = watchdog_count;
         end else if (addr_hit(reg_req.addr, ADDR_SWITCH_MODE_CONFIG)) begin
            next_reg_rdata = switch_mode_config;
         end else begin
            next_reg_rdata = 8'h00;
         end
      end
      next_irq = global_irq_enable && switch_mode_config[BIT_TAKEOVER_IRQ_ENABLE]
                 && (|hw_control_flag);
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         mode_cmd <= '0;
         power_on_grant <= '0;
         mode_wr_accept <= 1'b0;
         reg_rdata <= 8'h00;
         irq <= 1'b0;
      end else begin
         mode_cmd <= next_mode_cmd;
         power_on_grant <= next_power_on_grant;
         mode_wr_accept <= next_mode_wr_accept;
         reg_rdata <= next_reg_rdata;
         irq <= next_irq;
      end
   end
endmodule

// *** sim/pse_port_watchdog_fallback_test.sv ***
`timescale 1ns/1ns
module pse_port_watchdog_fallback_test
   import pwd_pkg::*;
;
   localparam int TC = 8;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic global_irq_enable = 1'b0;
   logic mode_wr_req = 1'b0;
   logic [3:0] power_on_req = 4'h0;
   logic [3:0] power_on_grant;
   logic [3:0] sel;
   logic [7:0] reg_rdata;
   logic [7:0] q;
   logic [31:0] seed = 32'h937C;
   logic mode_wr_accept;
   logic hw_control_active;
   logic irq;
   pwd_reg_req_t reg_req;
   pwd_mode_cmd_t mode_cmd;
   int err_count = 0;
   int comparisons = 0;
   int m_flags = 0;
   pwd_host i_host (.sys_clk(sys_clk), .reg_req(reg_req), .reg_rdata(reg_rdata));
   pwd_watchdog #(.TICK_CYCLES(TC)) i_pwd_watchdog (.sys_clk(sys_clk), .rst(rst),
      .reg_req(reg_req), .reg_rdata(reg_rdata), .global_irq_enable(global_irq_enable),
      .power_on_req(power_on_req), .mode_wr_req(mode_wr_req),
      .power_on_grant(power_on_grant), .mode_wr_accept(mode_wr_accept),
      .mode_cmd(mode_cmd), .hw_control_active(hw_control_active), .irq(irq));
   initial begin
      forever #25 sys_clk = ~sys_clk;
   end
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic results;
      $display("comparisons %0d err_count %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      comparisons++;
      if (g !== e) begin
         $display("Error %s expected %h seen %h", n, e, g);
         err_count++;
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      i_host.access(1'b1, a, d, q);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] e);
      i_host.access(1'b0, a, 8'h00, q);
      chk("read data", e, q);
   endtask
   // flag register model: takeover and refused power-on set, read clears
   task automatic rdf;
      rdc(ADDR_HW_CONTROL_FLAGS, 8'(m_flags));
      m_flags = 0;
   endtask
   task automatic pulse(input logic [3:0] r, input logic hw);
      @(negedge sys_clk);
      power_on_req = r;
      mode_wr_req = 1'b1;
      @(negedge sys_clk);
      power_on_req = 4'h0;
      mode_wr_req = 1'b0;
      chk("grant", hw ? 8'h00 : {4'h0, r}, {4'h0, power_on_grant});
      chk("accept", {7'h0, !hw}, {7'h0, mode_wr_accept});
      if (hw) begin
         m_flags = m_flags | r;
      end
   endtask
   task automatic wait_exp(input int lo, input int hi);
      int n;
      n = 0;
      while (mode_cmd.valid !== 1'b1 && n < hi) begin
         @(negedge sys_clk);
         n++;
      end
      if (n >= hi) begin
         err_count++;
         results();
      end else begin
         chk("expiry early", 8'h01, {7'h0, n >= lo});
         chk("active", 8'h01, {7'h0, hw_control_active});
         for (int i = 0; i < NUM_PORTS; i++) begin
            chk("mode", sel[i] ? 8'h03 : 8'h00, {6'h0, mode_cmd.mode[i]});
         end
         m_flags = 15;
      end
   endtask
   initial begin
      repeat (10) @(negedge sys_clk);
      rst = 1'b0;
      for (int a = 8'h1C; a < 8'h21; a++) begin
         rdc(a[7:0], 8'h00);
      end
      wr(ADDR_WATCHDOG_COUNT, 8'h05);
      wr(ADDR_SWITCH_MODE_CONFIG, 8'h10);
      repeat (60) @(negedge sys_clk);
      rdc(ADDR_WATCHDOG_COUNT, 8'h05);
      seed = lfsr(seed);
      pulse(seed[3:0], 1'b0);
      seed = lfsr(seed);
      sel = seed[3:0];
      global_irq_enable = 1'b1;
      wr(ADDR_SWITCH_MODE_CONFIG, {4'hC, sel});
      wr(ADDR_WATCHDOG_COUNT, 8'h03);
      wait_exp(2 * TC, 3 * TC + 4);
      repeat (2) @(negedge sys_clk);
      chk("irq", 8'h01, {7'h0, irq});
      rdc(ADDR_WATCHDOG_COUNT, 8'h00);
      rdf();
      rdf();
      pulse(seed[7:4] | 4'h1, 1'b1);
      rdf();
      repeat (40) @(negedge sys_clk);
      chk("held", 8'h01, {7'h0, hw_control_active});
      wr(ADDR_WATCHDOG_COUNT, 8'h02);
      chk("reload", 8'h00, {7'h0, hw_control_active});
      wait_exp(TC, 2 * TC + 4);
      global_irq_enable = 1'b0;
      repeat (3) @(negedge sys_clk);
      chk("irq off", 8'h00, {7'h0, irq});
      wr(ADDR_SWITCH_MODE_CONFIG, 8'h00);
      chk("disable", 8'h00, {7'h0, hw_control_active});
      pulse(4'hF, 1'b0);
      global_irq_enable = 1'b1;
      repeat (3) @(negedge sys_clk);
      chk("irq masked", 8'h00, {7'h0, irq});
      rdf();
      results();
   end
endmodule

// *** sim/pwd_host.sv ***
`timescale 1ns/1ns
module pwd_host
   import pwd_pkg::*;
(
   input wire logic sys_clk,
   output pwd_reg_req_t reg_req,
   input wire logic [7:0] reg_rdata
);
   initial reg_req = '0;
   task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d,
         output logic [7:0] q);
      @(negedge sys_clk);
      reg_req = '{addr: a, wr: w, rd: !w, wdata: d};
      @(negedge sys_clk);
      q = reg_rdata;
      // released bus shows inverted leftovers
      reg_req = '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: ~d};
   endtask
endmodule

// *** sim/pwd_watchdog_props.sv ***
`timescale 1ns/1ns
module pwd_watchdog_props
   import pwd_pkg::*;
#(
   parameter int TICK_CYCLES = 8
) (
   input wire logic sys_clk,
   input wire logic rst,
   input pwd_reg_req_t reg_req,
   input wire logic [7:0] reg_rdata,
   input wire logic global_irq_enable,
   input wire logic [NUM_PORTS-1:0] power_on_req,
   input wire logic mode_wr_req,
   input wire logic [NUM_PORTS-1:0] power_on_grant,
   input wire logic mode_wr_accept,
   input pwd_mode_cmd_t mode_cmd,
   input wire logic hw_control_active,
   input wire logic irq
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   wire logic wr_cnt = reg_req.wr && reg_req.addr == ADDR_WATCHDOG_COUNT;
   wire logic wr_cfg = reg_req.wr && reg_req.addr == ADDR_SWITCH_MODE_CONFIG;
   wire logic rd_map = reg_req.addr inside {ADDR_HW_CONTROL_FLAGS, ADDR_WATCHDOG_COUNT,
      ADDR_SWITCH_MODE_CONFIG};
   a_grant_refused: assert property (hw_control_active && |power_on_req |=>
      power_on_grant == 4'h0) else $error("power-on granted under takeover");
   a_mode_refused: assert property (hw_control_active && mode_wr_req |=>
      !mode_wr_accept) else $error("mode write accepted under takeover");
   a_mode_accepted: assert property (!hw_control_active && mode_wr_req |=>
      mode_wr_accept) else $error("mode write refused without takeover");
   a_cmd_single: assert property (mode_cmd.valid |=> !mode_cmd.valid)
      else $error("mode command longer than one cycle");
   a_takeover_cmd: assert property ($rose(hw_control_active) |-> mode_cmd.valid)
      else $error("takeover without mode command");
   a_reload_ends: assert property (wr_cnt && reg_req.wdata != 8'h00 |=>
      !hw_control_active) else $error("takeover kept after reload");
   a_disable_ends: assert property (wr_cfg && !reg_req.wdata[BIT_WATCHDOG_ENABLE] |=>
      !hw_control_active && !mode_cmd.valid) else $error("takeover kept while disabled");
   a_irq_global: assert property (irq |-> $past(global_irq_enable))
      else $error("interrupt without global enable");
   a_unmapped_zero: assert property (reg_req.rd && !rd_map |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   a_rdata_hold: assert property (!reg_req.rd |=> $stable(reg_rdata))
      else $error("read data moved without read");
   cover property (mode_cmd.valid);
   cover property (hw_control_active && |power_on_req);
   cover property (irq);
endmodule
bind pwd_watchdog pwd_watchdog_props #(.TICK_CYCLES(TICK_CYCLES)) i_pwd_watchdog_props (
   .sys_clk(sys_clk), .rst(rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
   .global_irq_enable(global_irq_enable), .power_on_req(power_on_req),
   .mode_wr_req(mode_wr_req), .power_on_grant(power_on_grant),
   .mode_wr_accept(mode_wr_accept), .mode_cmd(mode_cmd),
   .hw_control_active(hw_control_active), .irq(irq));
